// [common/etw_defs.vh]
// register map, field positions, reset values and timing for the 8-bit timer
// assumes byte addresses on an AXI4-Lite slave with 32-bit data
`ifndef ETW_DEFS_VH
`define ETW_DEFS_VH
// flags index sits off the word grid; the bus sees four times the index
`define ETW_IDX_FLAGS 8'h36
`define ETW_OFF_FLAGS 8'hD8
`define ETW_OFF_CTRL 8'h40
`define ETW_OFF_COUNT 8'h44
`define ETW_OFF_CMP 8'h48
`define ETW_OFF_MASK 8'h4C
`define ETW_OFF_GLOBAL 8'h50
`define ETW_OFF_PIN 8'h54
`define ETW_CTRL_FOC 7
`define ETW_CTRL_WGM1 3
`define ETW_CTRL_WGM0 6
`define ETW_CTRL_COM_HI 5
`define ETW_CTRL_COM_LO 4
`define ETW_CTRL_CS_HI 2
`define ETW_FLAG_CMP 7
`define ETW_FLAG_OVF 6
`define ETW_MASK_CMP 7
`define ETW_MASK_OVF 6
`define ETW_RST_BYTE 8'h00
`define ETW_TOP_MAX 8'hFF
`define ETW_BOTTOM 8'h00
`define ETW_DIV_8 10'd7
`define ETW_DIV_64 10'd63
`define ETW_DIV_256 10'd255
`define ETW_DIV_1024 10'd1023
`define ETW_AXI_OKAY 2'b00
`define ETW_AXI_SLVERR 2'b10
`endif

// [hdl/etw_edge_sync.v]
// two-flop synchroniser with rising/falling edge pulses
// assumes an asynchronous pin input and one clock domain
`timescale 1ns/1ps
module etw_edge_sync
(
	// clock and reset
	input wire clk,
	input wire nrst,
	// pin and edge pulses
	input wire pin_in,
	output wire rise,
	output wire fall
);
	reg s1_q;
	reg s2_q;
	reg s3_q;
	// first flop feeds only the second
	always @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end
		else
		begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	assign rise = s2_q & ~s3_q;
	assign fall = ~s2_q & s3_q;
endmodule

// [hdl/etw_timer.v]
// 8-bit timer/counter with waveform output, register side over AXI4-Lite
// assumes one clock; count pin is asynchronous; vector acks come from the core
//
// Contract
// - force compare works only in non-PWM modes
// - force strobe applies current compare output action
// - forced compare sets no flag, no clear
// - force strobe always reads back zero
// - mode field picks mode and top value
// - compare buffering and overflow point per mode
// - nonzero output action overrides port pin
// - non-PWM actions: none, toggle, clear, set
// - fast PWM: clear/set on match, inverse bottom
// - fast PWM compare at top skips match
// - phase PWM: action by count direction
// - phase PWM compare at top acts at top
// - clock select stops or picks prescaled clock
// - select 110/111 count pin falling/rising
// - pin edges count even when pin output
// - counter read/write; write blocks next match
// - compare register compared continuously with counter
// - compare irq needs enable, global, flag
// - overflow irq needs enable, global, flag
// - compare flag set on match, W1C/vector
// - overflow flag set on overflow, W1C/vector
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`include "etw_defs.vh"
module etw_timer
(
	// clock and reset
	input wire CLK,
	input wire NRST,
	// axi4-lite write address and data
	input wire [7:0] S_AXI_AWADDR,
	input wire S_AXI_AWVALID,
	output reg S_AXI_AWREADY,
	input wire [31:0] S_AXI_WDATA,
	input wire [3:0] S_AXI_WSTRB,
	input wire S_AXI_WVALID,
	output reg S_AXI_WREADY,
	// axi4-lite write response
	output reg [1:0] S_AXI_BRESP,
	output reg S_AXI_BVALID,
	input wire S_AXI_BREADY,
	// axi4-lite read
	input wire [7:0] S_AXI_ARADDR,
	input wire S_AXI_ARVALID,
	output reg S_AXI_ARREADY,
	output reg [31:0] S_AXI_RDATA,
	output reg [1:0] S_AXI_RRESP,
	output reg S_AXI_RVALID,
	input wire S_AXI_RREADY,
	// pins
	input wire EXTERNAL_COUNT_PIN,
	output reg WAVEFORM_OUTPUT,
	output reg WAVEFORM_OVERRIDE,
	// interrupt requests and vector acknowledges
	output reg COMPARE_IRQ,
	output reg OVERFLOW_IRQ,
	input wire COMPARE_VECTOR_ACK,
	input wire OVERFLOW_VECTOR_ACK
);
	localparam MODE_NORMAL = 2'b00;
	localparam MODE_PHASE = 2'b01;
	localparam MODE_CLR = 2'b10;
	localparam MODE_FAST = 2'b11;

	reg [7:0] count_q, cmp_q, cmp_buf_q, aw_addr_q;
	reg [1:0] wgm_q, com_q;
	reg [2:0] cs_q;
	reg cmp_flag_q, ovf_flag_q, cmp_ie_q, ovf_ie_q, global_ie_q;
	reg down_q, block_q, aw_have_q, w_have_q;
	reg [9:0] presc_q;
	reg [31:0] w_data_q;
	reg [3:0] w_strb_q;

	wire pin_rise, pin_fall;
	reg [7:0] top, count_d;
	reg tick, match, down_d, oc_d, set_cmp, set_ovf, act_set, act_clr;

	wire wr_go = aw_have_q & w_have_q & ~S_AXI_BVALID;
	wire wr_b0 = wr_go & w_strb_q[0];
	wire wr_ctrl = wr_b0 && aw_addr_q == `ETW_OFF_CTRL;
	wire wr_count = wr_b0 && aw_addr_q == `ETW_OFF_COUNT;
	wire pwm = wgm_q[0];
	wire foc = wr_ctrl & w_data_q[`ETW_CTRL_FOC] & ~w_data_q[`ETW_CTRL_WGM0];

	// pin sampled regardless of its direction
	etw_edge_sync u_sync
	(
		.clk(CLK),
		.nrst(NRST),
		.pin_in(EXTERNAL_COUNT_PIN),
		.rise(pin_rise),
		.fall(pin_fall)
	);

	// free-running prescaler; divided taps are one-cycle enables
	always @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
			presc_q <= 10'd0;
		else
			presc_q <= presc_q + 10'd1;
	end

	always @*
	begin
		case (cs_q)
			3'b000: tick = 1'b0;
			3'b001: tick = 1'b1;
			3'b010: tick = ((presc_q & `ETW_DIV_8) == `ETW_DIV_8);
			3'b011: tick = ((presc_q & `ETW_DIV_64) == `ETW_DIV_64);
			3'b100: tick = ((presc_q & `ETW_DIV_256) == `ETW_DIV_256);
			3'b101: tick = (presc_q == `ETW_DIV_1024);
			3'b110: tick = pin_fall;
			default: tick = pin_rise;
		endcase
	end

	// next count, direction, flags and output actions
	always @*
	begin
		top = (wgm_q == MODE_CLR) ? cmp_q : `ETW_TOP_MAX;
		match = (count_q == cmp_q) & ~block_q;
		count_d = count_q;
		down_d = down_q & (wgm_q == MODE_PHASE); // other modes restart phase counting upward
		set_cmp = 1'b0;
		set_ovf = 1'b0;
		act_set = 1'b0;
		act_clr = 1'b0;
		oc_d = WAVEFORM_OUTPUT;
		if (tick)
		begin
			set_cmp = match;
			case (wgm_q)
				MODE_PHASE:
				begin
					if (!down_q && count_q == `ETW_TOP_MAX)
						down_d = 1'b1;
					else if (down_q && count_q == `ETW_BOTTOM)
						down_d = 1'b0;
					count_d = down_d ? count_q - 8'd1 : count_q + 8'd1;
					set_ovf = down_q && count_q == `ETW_BOTTOM;
					if (com_q[1] && cmp_q == `ETW_TOP_MAX)
					begin
						if (count_q == `ETW_TOP_MAX)
						begin
							act_set = ~com_q[0];
							act_clr = com_q[0];
						end
					end
					else if (match && com_q[1])
					begin
						act_clr = down_q ? com_q[0] : ~com_q[0];
						act_set = down_q ? ~com_q[0] : com_q[0];
					end
				end
				MODE_FAST:
				begin
					count_d = count_q + 8'd1;
					set_ovf = count_q == `ETW_TOP_MAX;
					if (count_q == `ETW_TOP_MAX && com_q[1]) // bottom action
					begin
						act_set = ~com_q[0];
						act_clr = com_q[0];
					end
					else if (match && com_q[1] && cmp_q != `ETW_TOP_MAX)
					begin
						act_clr = ~com_q[0];
						act_set = com_q[0];
					end
				end
				default:
				begin
					// clear at compare value in clear mode
					count_d = (wgm_q == MODE_CLR && count_q == top) ? `ETW_BOTTOM : count_q + 8'd1;
					set_ovf = count_q == `ETW_TOP_MAX;
					if (match)
					begin
						act_set = (com_q == 2'b11) | ((com_q == 2'b01) & ~WAVEFORM_OUTPUT);
						act_clr = (com_q == 2'b10) | ((com_q == 2'b01) & WAVEFORM_OUTPUT);
					end
				end
			endcase
		end
		// forced match drives output only; flags and count untouched
		if (foc)
		begin
			act_set = (w_data_q[5:4] == 2'b11) | ((w_data_q[5:4] == 2'b01) & ~WAVEFORM_OUTPUT);
			act_clr = (w_data_q[5:4] == 2'b10) | ((w_data_q[5:4] == 2'b01) & WAVEFORM_OUTPUT);
		end
		if (act_set)
			oc_d = 1'b1;
		else if (act_clr)
			oc_d = 1'b0;
	end

	// counter, waveform, flags and registers
	always @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			count_q <= `ETW_RST_BYTE;
			cmp_q <= `ETW_RST_BYTE;
			cmp_buf_q <= `ETW_RST_BYTE;
			wgm_q <= 2'b00;
			com_q <= 2'b00;
			cs_q <= 3'b000;
			cmp_flag_q <= 1'b0;
			ovf_flag_q <= 1'b0;
			cmp_ie_q <= 1'b0;
			ovf_ie_q <= 1'b0;
			global_ie_q <= 1'b0;
			down_q <= 1'b0;
			block_q <= 1'b0;
			WAVEFORM_OUTPUT <= 1'b0;
			WAVEFORM_OVERRIDE <= 1'b0;
			COMPARE_IRQ <= 1'b0;
			OVERFLOW_IRQ <= 1'b0;
		end
		else
		begin
			down_q <= down_d;
			WAVEFORM_OUTPUT <= oc_d;
			WAVEFORM_OVERRIDE <= |com_q;
			// software write to the counter wins over counting
			if (wr_count)
				count_q <= w_data_q[7:0];
			else
				count_q <= count_d;
			// block clears at next tick after a counter write
			if (wr_count)
				block_q <= 1'b1;
			else if (tick)
				block_q <= 1'b0;
			// compare register double buffer
			if (wr_b0 && aw_addr_q == `ETW_OFF_CMP)
				cmp_buf_q <= w_data_q[7:0];
			if (wgm_q == MODE_NORMAL || wgm_q == MODE_CLR)
				cmp_q <= (wr_b0 && aw_addr_q == `ETW_OFF_CMP) ? w_data_q[7:0] : cmp_buf_q;
			else if (tick && wgm_q == MODE_PHASE && count_q == `ETW_TOP_MAX)
				cmp_q <= cmp_buf_q;
			else if (tick && wgm_q == MODE_FAST && count_q == `ETW_TOP_MAX)
				cmp_q <= cmp_buf_q;
			if (wr_ctrl)
			begin
				wgm_q <= {w_data_q[`ETW_CTRL_WGM1], w_data_q[`ETW_CTRL_WGM0]};
				com_q <= w_data_q[`ETW_CTRL_COM_HI:`ETW_CTRL_COM_LO];
				cs_q <= w_data_q[`ETW_CTRL_CS_HI:0];
			end
			if (wr_b0 && aw_addr_q == `ETW_OFF_MASK)
			begin
				cmp_ie_q <= w_data_q[`ETW_MASK_CMP];
				ovf_ie_q <= w_data_q[`ETW_MASK_OVF];
			end
			if (wr_b0 && aw_addr_q == `ETW_OFF_GLOBAL)
				global_ie_q <= w_data_q[0];
			// set wins over clear
			if (set_cmp)
				cmp_flag_q <= 1'b1;
			else if (COMPARE_VECTOR_ACK || (wr_b0 && aw_addr_q == `ETW_OFF_FLAGS
				&& w_data_q[`ETW_FLAG_CMP]))
				cmp_flag_q <= 1'b0;
			if (set_ovf)
				ovf_flag_q <= 1'b1;
			else if (OVERFLOW_VECTOR_ACK || (wr_b0 && aw_addr_q == `ETW_OFF_FLAGS
				&& w_data_q[`ETW_FLAG_OVF]))
				ovf_flag_q <= 1'b0;
			COMPARE_IRQ <= cmp_ie_q & global_ie_q & cmp_flag_q;
			OVERFLOW_IRQ <= ovf_ie_q & global_ie_q & ovf_flag_q;
		end
	end

	// axi write: address and data taken in either order or in the same cycle, one write at a time
	always @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY <= 1'b0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= `ETW_AXI_OKAY;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
		end
		else
		begin
			S_AXI_AWREADY <= ~aw_have_q & ~S_AXI_AWREADY & S_AXI_AWVALID & ~S_AXI_BVALID;
			S_AXI_WREADY <= ~w_have_q & ~S_AXI_WREADY & S_AXI_WVALID & ~S_AXI_BVALID;
			if (S_AXI_AWVALID && S_AXI_AWREADY)
			begin
				aw_have_q <= 1'b1;
				aw_addr_q <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && S_AXI_WREADY)
			begin
				w_have_q <= 1'b1;
				w_data_q <= S_AXI_WDATA;
				w_strb_q <= S_AXI_WSTRB;
			end
			if (wr_go)
			begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				if (aw_addr_q == `ETW_OFF_FLAGS || aw_addr_q == `ETW_OFF_CTRL
					|| aw_addr_q == `ETW_OFF_COUNT || aw_addr_q == `ETW_OFF_CMP
					|| aw_addr_q == `ETW_OFF_MASK || aw_addr_q == `ETW_OFF_GLOBAL)
					S_AXI_BRESP <= `ETW_AXI_OKAY;
				else
					S_AXI_BRESP <= `ETW_AXI_SLVERR;
			end
			else if (S_AXI_BVALID && S_AXI_BREADY)
				S_AXI_BVALID <= 1'b0;
		end
	end

	// axi read: one cycle to accept, data the next
	always @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h00000000;
			S_AXI_RRESP <= `ETW_AXI_OKAY;
		end
		else
		begin
			S_AXI_ARREADY <= ~S_AXI_ARREADY & ~S_AXI_RVALID & S_AXI_ARVALID;
			if (S_AXI_ARVALID && S_AXI_ARREADY)
			begin
				S_AXI_RVALID <= 1'b1;
				S_AXI_RRESP <= `ETW_AXI_OKAY;
				if (S_AXI_ARADDR == `ETW_OFF_FLAGS)
					S_AXI_RDATA <= {24'h000000, cmp_flag_q, ovf_flag_q, 6'h00};
				else if (S_AXI_ARADDR == `ETW_OFF_CTRL)
					S_AXI_RDATA <= {24'h000000, 1'b0, wgm_q[0], com_q, wgm_q[1], cs_q};
				else if (S_AXI_ARADDR == `ETW_OFF_COUNT)
					S_AXI_RDATA <= {24'h000000, count_q};
				else if (S_AXI_ARADDR == `ETW_OFF_CMP)
					S_AXI_RDATA <= {24'h000000, cmp_buf_q};
				else if (S_AXI_ARADDR == `ETW_OFF_MASK)
					S_AXI_RDATA <= {24'h000000, cmp_ie_q, ovf_ie_q, 6'h00};
				else if (S_AXI_ARADDR == `ETW_OFF_GLOBAL)
					S_AXI_RDATA <= {31'h00000000, global_ie_q};
				else
				begin
					S_AXI_RDATA <= 32'h00000000;
					S_AXI_RRESP <= `ETW_AXI_SLVERR;
				end
			end
			else if (S_AXI_RVALID && S_AXI_RREADY)
				S_AXI_RVALID <= 1'b0;
		end
	end
endmodule

// [tb/etw_timer_asserts.sv]
// checker: bus handshake and pin override relations of the timer
// assumes a bind onto etw_timer, one clock domain
`timescale 1ns/1ps
module etw_timer_asserts
(
	// clock and reset
	input wire CLK,
	input wire NRST,
	// bus handshakes
	input wire S_AXI_AWVALID,
	input wire S_AXI_AWREADY,
	input wire S_AXI_BVALID,
	input wire S_AXI_BREADY,
	input wire S_AXI_ARVALID,
	input wire S_AXI_ARREADY,
	input wire S_AXI_RVALID,
	input wire [1:0] S_AXI_RRESP,
	input wire [31:0] S_AXI_RDATA,
	// pin
	input wire WAVEFORM_OVERRIDE
);
	default clocking @(posedge CLK);
	endclocking
	default disable iff (!NRST);
	sequence wr_take;
		S_AXI_AWVALID && S_AXI_AWREADY;
	endsequence
	sequence rd_take;
		S_AXI_ARVALID && S_AXI_ARREADY;
	endsequence
	aw_pulse_a: assert property (S_AXI_AWREADY |=> !S_AXI_AWREADY)
		else $error("awready held");
	ar_pulse_a: assert property (S_AXI_ARREADY |=> !S_AXI_ARREADY)
		else $error("arready held");
	read_answer_a: assert property (rd_take |=> S_AXI_RVALID)
		else $error("read late");
	write_answer_a: assert property (wr_take |=> ##[0:1] S_AXI_BVALID)
		else $error("write late");
	bresp_done_a: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
		else $error("bvalid stuck");
	aw_refuse_a: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY)
		else $error("aw taken early");
	unmapped_zero_a: assert property (S_AXI_RVALID && S_AXI_RRESP[1] |-> S_AXI_RDATA == 0)
		else $error("error data");
	// override only moves as a control write lands
	override_write_a: assert property ($changed(WAVEFORM_OVERRIDE) |->
		S_AXI_BVALID || $past(S_AXI_BVALID)) else $error("override moved");
endmodule
bind etw_timer etw_timer_asserts chk_i (.*);

// [tb/testbench.sv]
// testbench: registers, waveform, flags and count sources of the timer
// assumes etw_timer with its checker bound, 250 MHz clock
`timescale 1ns/1ps
`include "etw_defs.vh"
module testbench;
	localparam logic [7:0] fl = `ETW_OFF_FLAGS, ct = `ETW_OFF_CTRL, cn = `ETW_OFF_COUNT;
	localparam logic [7:0] cp = `ETW_OFF_CMP, mk = `ETW_OFF_MASK, gl = `ETW_OFF_GLOBAL;
	logic CLK = '0, NRST = '0;
	logic [7:0] S_AXI_AWADDR = '0, S_AXI_ARADDR = '0;
	logic [31:0] S_AXI_WDATA = '0;
	logic [3:0] S_AXI_WSTRB = 4'hF;
	logic S_AXI_AWVALID = '0, S_AXI_WVALID = '0, S_AXI_BREADY = '0;
	logic S_AXI_ARVALID = '0, S_AXI_RREADY = '0;
	logic EXTERNAL_COUNT_PIN = '0, COMPARE_VECTOR_ACK = '0, OVERFLOW_VECTOR_ACK = '0;
	wire S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
	wire [1:0] S_AXI_BRESP, S_AXI_RRESP;
	wire [31:0] S_AXI_RDATA;
	wire WAVEFORM_OUTPUT, WAVEFORM_OVERRIDE, COMPARE_IRQ, OVERFLOW_IRQ;
	int err_count = 0;
	int total_checks = 0;
	int n;
	int dv[4] = '{8, 64, 256, 1024};
	logic [7:0] m[256] = '{default: 8'h0};
	logic [7:0] ra[6] = '{fl, ct, cn, cp, mk, gl};
	logic [9:0] ft[8] = '{{8'hB0, 2'h3}, {8'hA0, 2'h1}, {8'h90, 2'h3}, {8'h90, 2'h1},
		{8'hF8, 2'h1}, {8'hF0, 2'h1}, {8'hB8, 2'h3}, {8'h80, 2'h2}};
	logic [31:0] d;
	logic [1:0] s;
	etw_timer dut (.*);
	initial
	begin
		forever #2 CLK = ~CLK;
	end
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge CLK);
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= {24'h0, v};
		S_AXI_AWVALID <= 1'h1;
		S_AXI_WVALID <= 1'h1;
		S_AXI_BREADY <= 1'h1;
		do
		begin
			@(posedge CLK);
			if (S_AXI_AWREADY)
				S_AXI_AWVALID <= 1'h0;
			if (S_AXI_WREADY)
				S_AXI_WVALID <= 1'h0;
		end
		while (!S_AXI_BVALID);
		S_AXI_BREADY <= 1'h0;
		m[a] = (a == ct) ? v & 8'h7F : (a == fl) ? 8'h00 : v;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge CLK);
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1'h1;
		S_AXI_RREADY <= 1'h1;
		do
		begin
			@(posedge CLK);
			if (S_AXI_ARREADY)
				S_AXI_ARVALID <= 1'h0;
		end
		while (!S_AXI_RVALID);
		S_AXI_RREADY <= 1'h0;
		d = S_AXI_RDATA;
		s = S_AXI_RRESP;
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		rd(a);
		chk($sformatf("reg %h", a), d, {24'h0, e});
	endtask
	task automatic run(input logic [7:0] c, input int t);
		wr(ct, c);
		repeat (t) @(posedge CLK);
		wr(ct, c & 8'hF8);
	endtask
	task results;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		#200000;
		err_count++;
		results();
	end
	initial
	begin
		n = $urandom(32'h849D);
		repeat (12) @(posedge CLK);
		NRST <= 1'h1;
		foreach (ra[i]) rc(ra[i], 8'h0);
		repeat (4)
		begin
			n = $urandom;
			wr(cp, n[7:0]);
			wr(mk, n[15:8] & 8'hC0);
			wr(ct, n[23:16] & (n[22] ? 8'h78 : 8'hF8));
			wr(gl, {7'h0, n[24]});
			foreach (ra[i]) rc(ra[i], m[ra[i]]);
		end
		rd(8'hF0);
		chk("resp", s, `ETW_AXI_SLVERR);
		wr(cn, 8'h10);
		wr(cp, 8'h80);
		wr(mk, 8'hC0);
		wr(gl, 8'h1);
		foreach (ft[i])
		begin
			wr(ct, ft[i][9:2]);
			repeat (2) @(posedge CLK);
			chk("out", WAVEFORM_OUTPUT, ft[i][1]);
			chk("ovr", WAVEFORM_OVERRIDE, ft[i][0]);
		end
		rc(fl, 8'h0);
		rc(cn, 8'h10);
		wr(cn, 8'h0);
		wr(cp, 8'h5);
		run(8'h11, 20);
		rc(fl, 8'h80);
		chk("out", WAVEFORM_OUTPUT, 1'h0);
		chk("cirq", COMPARE_IRQ, 1'h1);
		wr(gl, 8'h0);
		repeat (2) @(posedge CLK);
		chk("cirq", COMPARE_IRQ, 1'h0);
		wr(gl, 8'h1);
		wr(fl, 8'h80);
		rc(fl, 8'h0);
		wr(cn, 8'h5);
		run(8'h11, 8);
		rc(fl, 8'h0);
		wr(cn, 8'hF0);
		run(8'h01, 30);
		rc(fl, 8'hC0);
		chk("oirq", OVERFLOW_IRQ, 1'h1);
		COMPARE_VECTOR_ACK <= 1'h1;
		OVERFLOW_VECTOR_ACK <= 1'h1;
		@(posedge CLK);
		COMPARE_VECTOR_ACK <= 1'h0;
		OVERFLOW_VECTOR_ACK <= 1'h0;
		rc(fl, 8'h0);
		chk("oirq", OVERFLOW_IRQ, 1'h0);
		wr(cn, 8'hF0);
		run(8'h41, 30);
		rc(fl, 8'h0);
		wr(cp, 8'h3);
		wr(cn, 8'h0);
		run(8'h09, 30);
		rd(cn);
		chk("top", d <= 3, 1'h1);
		rc(fl, 8'h80);
		foreach (dv[i])
		begin
			wr(cn, 8'h0);
			run(8'(2 + i), dv[i] * 6);
			rd(cn);
			chk("div", d >= 5 && d <= 7, 1'h1);
		end
		// last edge left high so the two polarities give different counts
		for (int e = 6; e < 8; e++)
		begin
			n = $urandom_range(9, 2);
			wr(cn, 8'h0);
			wr(ct, 8'(e));
			repeat (n)
			begin
				EXTERNAL_COUNT_PIN <= 1'h0;
				repeat (6) @(posedge CLK);
				EXTERNAL_COUNT_PIN <= 1'h1;
				repeat (6) @(posedge CLK);
			end
			wr(ct, 8'h0);
			EXTERNAL_COUNT_PIN <= 1'h0;
			rc(cn, 8'(n - 7 + e));
		end
		// pwm waveforms: counter passes the compare value, then the turn points
		wr(cp, 8'h80);
		wr(cn, 8'h70);
		run(8'h69, 20);
		chk("fast match", WAVEFORM_OUTPUT, 1'h0);
		run(8'h69, 130);
		chk("fast bottom", WAVEFORM_OUTPUT, 1'h1);
		wr(cn, 8'h70);
		run(8'h61, 20);
		chk("phase up", WAVEFORM_OUTPUT, 1'h0);
		run(8'h61, 250);
		chk("phase down", WAVEFORM_OUTPUT, 1'h1);
		wr(ct, 8'h00);
		wr(cp, 8'hFF);
		wr(cn, 8'hF0);
		run(8'h71, 20);
		chk("phase top", WAVEFORM_OUTPUT, 1'h0);
		results();
	end
endmodule
